/* File: fcac_regs.svh */
// Purpose: constants for the flash command interpreter and its host controller
// Assumes: 16-bit data, 20-bit word address, four banks on the top two address bits
// Notes:   command codes and bank split are free choices of this design
`ifndef FCAC_REGS_SVH
`define FCAC_REGS_SVH
`define FCAC_AW            20
`define FCAC_DW            16
// configuration fields carried on the address of the final configuration cycle
`define FCAC_CFG_MODE_BIT  19
`define FCAC_CFG_RDY_BIT   18
`define FCAC_CFG_EDGE_BIT  17
`define FCAC_CFG_BURST_HI  16
`define FCAC_CFG_BURST_LO  15
`define FCAC_CFG_WAIT_HI   14
`define FCAC_CFG_WAIT_LO   12
`define FCAC_CFG_RESET     8'he5
`define FCAC_WAIT_DEFAULT  3'h5
`define FCAC_WAIT_RSVD     3'h6
// bank address is the top two address bits
`define FCAC_BANK_HI       19
`define FCAC_BANK_LO       18
`define FCAC_SECT_HI       17
`define FCAC_SECT_LO       15
// unlock and command codes
`define FCAC_UNLOCK1_ADDR  12'h555
`define FCAC_UNLOCK2_ADDR  12'h2aa
`define FCAC_UNLOCK1_DATA  16'h00aa
`define FCAC_UNLOCK2_DATA  16'h0055
`define FCAC_CMD_RESET     16'h00f0
`define FCAC_CMD_AUTOSEL   16'h0090
`define FCAC_CMD_SEC_ENTER 16'h0088
`define FCAC_CMD_SEC_EXIT  16'h0090
`define FCAC_CMD_SEC_EXIT2 16'h0000
`define FCAC_CMD_CFG       16'h00c0
`define FCAC_CMD_PROGRAM   16'h00a0
`define FCAC_CMD_ERASE     16'h0080
`define FCAC_CMD_ERASE_GO  16'h0030
// autoselect offsets
`define FCAC_AS_MFR        8'h00
`define FCAC_AS_DEV1       8'h01
`define FCAC_AS_LOCK       8'h02
`define FCAC_AS_IND        8'h03
`define FCAC_AS_DEV2       8'h0e
`define FCAC_AS_DEV3       8'h0f
`define FCAC_LOCKED        16'h0001
`define FCAC_UNLOCKED      16'h0000
`define FCAC_IND_FACT_BIT  7
`define FCAC_IND_CUST_BIT  6
`define FCAC_IND_HS_BIT    5
`define FCAC_ESN_WORDS     8
// host register map over ahb-lite
`define FCAC_HREG_ADDR     8'h00
`define FCAC_HREG_DATA     8'h04
`define FCAC_HREG_CTRL     8'h08
`define FCAC_HREG_STATUS   8'h0c
`define FCAC_HREG_RDATA    8'h10
`endif

/* File: fcac_pkg.sv */
// Purpose: shared types of the flash command interpreter
// Assumes: fcac_regs.svh for numbers
// Notes:   none
package fcac_pkg;
  typedef enum logic [2:0] {
    FCAC_CMD_IDLE = 3'b000,
    FCAC_CMD_U1   = 3'b001,
    FCAC_CMD_U2   = 3'b010,
    FCAC_CMD_PGM  = 3'b011,
    FCAC_CMD_ER3  = 3'b100,
    FCAC_CMD_ER4  = 3'b101,
    FCAC_CMD_ER5  = 3'b110,
    FCAC_CMD_SX   = 3'b111
  } fcac_seq_t;
  typedef enum logic [1:0] {
    FCAC_BANK_READ    = 2'b00,
    FCAC_BANK_AUTOSEL = 2'b01,
    FCAC_BANK_BUSY    = 2'b10
  } fcac_bank_t;
endpackage : fcac_pkg

/* File: fcac_if.sv */
// Purpose: flash bus between host controller and device command logic
// Assumes: single clock hclk, one word per cycle
// Notes:   we_n/re_n are one-cycle strobes from the host
`timescale 1ns/1ps
`include "fcac_regs.svh"
interface fcac_if;
  logic                 avs_n;
  logic                 we_n;
  logic                 re_n;
  logic [`FCAC_AW-1:0]  addr;
  logic [`FCAC_DW-1:0]  wdata;
  logic [`FCAC_DW-1:0]  rdata;
  logic                 rvalid;
  logic                 rdy_o;
  logic                 rdy_oe;
  modport device (input avs_n, input we_n, input re_n, input addr, input wdata,
                  output rdata, output rvalid, output rdy_o, output rdy_oe);
  modport host (output avs_n, output we_n, output re_n, output addr, output wdata,
                input rdata, input rvalid, input rdy_o, input rdy_oe);
endinterface : fcac_if

/* File: fcac_device.sv */
// Purpose: command interpreter of a multi-bank burst flash
// Assumes: host drives strobes synchronously on hclk
// Notes:   array contents come in on array_rdata; program/erase timing from algo_busy
//
// Contract
// - a17 selects rising or falling active edge
// - a18 sets ready with data or early
// - a19 chooses burst or asynchronous reads
// - a16:a15 select burst length or continuous
// - wait code 011 is 5, 100 is 6
// - every field defaults on any reset; here only hresetn restores them, the reset command leaves cfg as set
// - reset command returns banks, address ignored
// - reset aborts erase setup, ignored while erasing
// - reset aborts program setup, ignored while programming
// - autoselect left only by reset command
// - reset after limit exceeded returns to read
// - host autoselects only idle banks
// - two unlocks plus bank command enter autoselect
// - burst autoselect read gives one word only
// - autoselect reads repeat; other banks read array
// - offsets 00,01,0e,0f give identity words
// - offset 02 per sector gives lock state
// - offset 03 gives indicator bits, upper zero
// - three-cycle entry, four-cycle exit of region
// - secured region unavailable while algorithm runs
// - region holds eight-word serial number
// - wait codes give 2..7 cycles, 6,7 reserved
//
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "fcac_regs.svh"
module fcac_device #(
  parameter logic [15:0] MFR_CODE  = 16'h0a5a, // arbitrary
  parameter logic [15:0] DEV_CODE1 = 16'h1111, // arbitrary
  parameter logic [15:0] DEV_CODE2 = 16'h2222, // arbitrary
  parameter logic [15:0] DEV_CODE3 = 16'h3333, // arbitrary
  parameter logic [127:0] ELECTRONIC_SERIAL_NUMBER      = 128'h0123456789abcdeffedcba9876543210
) (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  fcac_if.device                    bus,
  input  wire logic [`FCAC_DW-1:0]  array_rdata,
  input  wire logic [7:0]           sector_lock,
  input  wire logic                 factory_lock,
  input  wire logic                 customer_lock,
  input  wire logic                 reduced_hs,
  input  wire logic                 exceeded_limit_bit,
  input  wire logic [3:0]           algo_busy,
  input  wire logic [3:0]           suspended,
  output logic                      sync_mode,
  output logic                      rdy_early,
  output logic                      rising_edge_sel,
  output logic [1:0]                burst_len,
  output logic [2:0]                wait_code,
  output logic [3:0]                autosel_bank,
  output logic                      secured_region,
  output logic [3:0]                abort_bank
);
  fcac_pkg::fcac_seq_t seq;
  fcac_pkg::fcac_seq_t next_seq;
  logic [7:0]  cfg;
  logic [1:0]  bank_sel;
  logic [1:0]  wr_bank;
  logic [1:0]  pend_bank;
  logic        pend;
  logic        wr;
  logic        is_reset;
  logic        any_busy;
  logic        burst_rd;
  logic [3:0]  busy_s1;
  logic [3:0]  busy_s2;
  logic        lim_s1;
  logic        lim_s2;
  logic [15:0] as_word;

  function automatic logic is_unlock(input logic [`FCAC_AW-1:0] a, input logic [15:0] d, input logic first);
    is_unlock = first ? (a[11:0] == `FCAC_UNLOCK1_ADDR && d == `FCAC_UNLOCK1_DATA)
                      : (a[11:0] == `FCAC_UNLOCK2_ADDR && d == `FCAC_UNLOCK2_DATA);
  endfunction : is_unlock

  // status inputs come from the array core, outside hclk timing
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      busy_s1 <= 4'h0;
      busy_s2 <= 4'h0;
      lim_s1  <= 1'b0;
      lim_s2  <= 1'b0;
    end
    else
    begin
      busy_s1 <= algo_busy;
      busy_s2 <= busy_s1;
      lim_s1  <= exceeded_limit_bit;
      lim_s2  <= lim_s1;
    end
  end

  assign wr       = !bus.we_n;
  assign is_reset = wr && bus.wdata == `FCAC_CMD_RESET;
  assign wr_bank  = bus.addr[`FCAC_BANK_HI:`FCAC_BANK_LO];
  assign bank_sel = bus.addr[`FCAC_BANK_HI:`FCAC_BANK_LO];
  assign any_busy = |busy_s2;
  assign burst_rd = !cfg[`FCAC_CFG_MODE_BIT-`FCAC_CFG_WAIT_LO];

  // command sequencer; reset command drops any partial sequence
  always_comb
  begin
    next_seq = seq;
    if (wr)
    begin
      if (is_reset)
        next_seq = fcac_pkg::FCAC_CMD_IDLE;
      else
        case (seq)
          fcac_pkg::FCAC_CMD_IDLE: next_seq = is_unlock(bus.addr, bus.wdata, 1'b1) ?
                                     fcac_pkg::FCAC_CMD_U1 : fcac_pkg::FCAC_CMD_IDLE;
          fcac_pkg::FCAC_CMD_U1:   next_seq = is_unlock(bus.addr, bus.wdata, 1'b0) ?
                                     fcac_pkg::FCAC_CMD_U2 : fcac_pkg::FCAC_CMD_IDLE;
          fcac_pkg::FCAC_CMD_U2:
          begin
            if (bus.wdata == `FCAC_CMD_PROGRAM)
              next_seq = fcac_pkg::FCAC_CMD_PGM;
            else if (bus.wdata == `FCAC_CMD_ERASE)
              next_seq = fcac_pkg::FCAC_CMD_ER3;
            else if (bus.wdata == `FCAC_CMD_SEC_EXIT && secured_region)
              next_seq = fcac_pkg::FCAC_CMD_SX;
            else
              next_seq = fcac_pkg::FCAC_CMD_IDLE;
          end
          fcac_pkg::FCAC_CMD_ER3:  next_seq = is_unlock(bus.addr, bus.wdata, 1'b1) ?
                                     fcac_pkg::FCAC_CMD_ER4 : fcac_pkg::FCAC_CMD_IDLE;
          fcac_pkg::FCAC_CMD_ER4:  next_seq = is_unlock(bus.addr, bus.wdata, 1'b0) ?
                                     fcac_pkg::FCAC_CMD_ER5 : fcac_pkg::FCAC_CMD_IDLE;
          default:                 next_seq = fcac_pkg::FCAC_CMD_IDLE;
        endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      seq <= fcac_pkg::FCAC_CMD_IDLE;
    else
      seq <= next_seq;
  end

  // abort pulse toward the array core for the bank in command setup
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      abort_bank <= 4'h0;
      pend       <= 1'b0;
      pend_bank  <= 2'h0;
    end
    else
    begin
      abort_bank <= 4'h0;
      if (wr && seq == fcac_pkg::FCAC_CMD_U2)
      begin
        pend      <= 1'b1;
        pend_bank <= wr_bank;
      end
      if (is_reset && pend && !busy_s2[pend_bank])
      begin
        abort_bank[pend_bank] <= 1'b1;
        pend                  <= 1'b0;
      end
      else if (wr && (seq == fcac_pkg::FCAC_CMD_PGM || seq == fcac_pkg::FCAC_CMD_ER5))
        pend <= 1'b0;
      // after a limit fault, reset clears the faulted banks back to read
      if (is_reset && lim_s2)
        abort_bank <= busy_s2;
    end
  end

  // configuration word taken from address of the final cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cfg <= `FCAC_CFG_RESET;
    else if (wr && seq == fcac_pkg::FCAC_CMD_U2 && bus.wdata == `FCAC_CMD_CFG &&
             bus.addr[`FCAC_CFG_WAIT_HI:`FCAC_CFG_WAIT_LO] < `FCAC_WAIT_RSVD)
      cfg <= bus.addr[`FCAC_CFG_MODE_BIT:`FCAC_CFG_WAIT_LO];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync_mode       <= 1'b0;
      rdy_early       <= 1'b0;
      rising_edge_sel <= 1'b1;
      burst_len       <= 2'h0;
      wait_code       <= `FCAC_WAIT_DEFAULT;
    end
    else
    begin
      sync_mode       <= !cfg[`FCAC_CFG_MODE_BIT-`FCAC_CFG_WAIT_LO];
      rdy_early       <= !cfg[`FCAC_CFG_RDY_BIT-`FCAC_CFG_WAIT_LO];
      rising_edge_sel <= cfg[`FCAC_CFG_EDGE_BIT-`FCAC_CFG_WAIT_LO];
      burst_len       <= cfg[`FCAC_CFG_BURST_HI-`FCAC_CFG_WAIT_LO:`FCAC_CFG_BURST_LO-`FCAC_CFG_WAIT_LO];
      wait_code       <= cfg[`FCAC_CFG_WAIT_HI-`FCAC_CFG_WAIT_LO:0];
    end
  end

  // bank modes: autoselect and secured region
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      autosel_bank   <= 4'h0;
      secured_region <= 1'b0;
    end
    else if (is_reset)
      autosel_bank <= 4'h0;
    else if (wr && seq == fcac_pkg::FCAC_CMD_U2)
    begin
      if (bus.wdata == `FCAC_CMD_AUTOSEL && !any_busy && !secured_region)
        autosel_bank[wr_bank] <= 1'b1;
      else if (bus.wdata == `FCAC_CMD_SEC_ENTER && !any_busy)
        secured_region <= 1'b1;
    end
    else if (wr && seq == fcac_pkg::FCAC_CMD_SX && bus.wdata == `FCAC_CMD_SEC_EXIT2)
      secured_region <= 1'b0;
  end

  always_comb
  begin
    case (bus.addr[7:0])
      `FCAC_AS_MFR:  as_word = MFR_CODE;
      `FCAC_AS_DEV1: as_word = DEV_CODE1;
      `FCAC_AS_DEV2: as_word = DEV_CODE2;
      `FCAC_AS_DEV3: as_word = DEV_CODE3;
      `FCAC_AS_LOCK: as_word = sector_lock[bus.addr[`FCAC_SECT_HI:`FCAC_SECT_LO]] ?
                               `FCAC_LOCKED : `FCAC_UNLOCKED;
      `FCAC_AS_IND:  as_word = {8'h00, factory_lock, customer_lock, reduced_hs, 5'h00};
      default:       as_word = 16'h0000;
    endcase
  end

  // read path; a burst read of autoselect data yields just one word
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus.rdata  <= 16'h0000;
      bus.rvalid <= 1'b0;
      bus.rdy_o  <= 1'b0;
      bus.rdy_oe <= 1'b0;
    end
    else
    begin
      bus.rvalid <= !bus.re_n;
      bus.rdy_o  <= !bus.re_n;
      bus.rdy_oe <= !bus.re_n && !burst_rd;
      if (!bus.re_n)
      begin
        if (secured_region && !any_busy)
          bus.rdata <= ELECTRONIC_SERIAL_NUMBER[bus.addr[2:0]*16 +: 16];
        else if (autosel_bank[bank_sel])
          bus.rdata <= (burst_rd && bus.avs_n) ? 16'h0000 : as_word;
        else
          bus.rdata <= array_rdata;
      end
    end
  end
endmodule : fcac_device

/* File: fcac_host.sv */
// Purpose: host controller issuing flash bus cycles from ahb-lite registers
// Assumes: one outstanding flash cycle at a time
// Notes:   ctrl write bit0 starts a write, bit1 a read
`timescale 1ns/1ps
`include "fcac_regs.svh"
module fcac_host (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  fcac_if.host             bus
);
  logic [19:0] addr_r;
  logic [15:0] data_r;
  logic [15:0] rd_r;
  logic        busy;
  logic        dph_wr;
  logic [7:0]  dph_addr;
  logic        go_wr;
  logic        go_rd;
  logic        rv_s1;
  logic        rv_s2;

  assign go_wr = dph_wr && dph_addr == `FCAC_HREG_CTRL && hwdata[0] && !busy;
  assign go_rd = dph_wr && dph_addr == `FCAC_HREG_CTRL && hwdata[1] && !busy;

  // ahb-lite slave: zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_wr    <= 1'b0;
      dph_addr  <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      dph_wr   <= hsel && hready && htrans[1] && hwrite;
      dph_addr <= haddr;
      if (hsel && hready && htrans[1] && !hwrite)
        case (haddr)
          `FCAC_HREG_ADDR:   hrdata <= {12'h000, addr_r};
          `FCAC_HREG_DATA:   hrdata <= {16'h0000, data_r};
          `FCAC_HREG_STATUS: hrdata <= {31'h0, busy};
          `FCAC_HREG_RDATA:  hrdata <= {16'h0000, rd_r};
          default:           hrdata <= 32'h0000_0000;
        endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_r <= 20'h00000;
      data_r <= 16'h0000;
    end
    else if (dph_wr && dph_addr == `FCAC_HREG_ADDR)
      addr_r <= hwdata[19:0];
    else if (dph_wr && dph_addr == `FCAC_HREG_DATA)
      data_r <= hwdata[15:0];
  end

  // flash cycle: strobe one clock, read waits for rvalid; reset only via command
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus.avs_n <= 1'b1;
      bus.we_n  <= 1'b1;
      bus.re_n  <= 1'b1;
      bus.addr  <= 20'h00000;
      bus.wdata <= 16'h0000;
      busy      <= 1'b0;
      rd_r      <= 16'h0000;
    end
    else
    begin
      bus.avs_n <= !(go_wr || go_rd);
      bus.we_n  <= !go_wr;
      bus.re_n  <= !go_rd;
      if (go_wr || go_rd)
      begin
        bus.addr  <= addr_r;
        bus.wdata <= data_r;
      end
      if (go_rd)
        busy <= 1'b1;
      else if (bus.rvalid)
      begin
        busy <= 1'b0;
        rd_r <= bus.rdata;
      end
    end
  end
endmodule : fcac_host

/* File: fcac_chk.sv */
// Purpose: assertions on the flash bus between host and device
// Assumes: command codes of fcac_regs.svh
// Notes:   command state is shadowed from the write strobes
`timescale 1ns/1ps
`include "fcac_regs.svh"
module fcac_chk #(
  parameter logic [15:0]  MFR_CODE  = 16'h0000,
  parameter logic [15:0]  DEV_CODE1 = 16'h0000,
  parameter logic [15:0]  DEV_CODE2 = 16'h0000,
  parameter logic [15:0]  DEV_CODE3 = 16'h0000,
  parameter logic [127:0] ELECTRONIC_SERIAL_NUMBER       = 128'h0
) (
  input wire logic                hclk,
  input wire logic                hresetn,
  input wire logic                avs_n,
  input wire logic                we_n,
  input wire logic                re_n,
  input wire logic [`FCAC_AW-1:0] addr,
  input wire logic [`FCAC_DW-1:0] wdata,
  input wire logic [`FCAC_DW-1:0] rdata,
  input wire logic                rvalid,
  input wire logic                rdy_o,
  input wire logic                rdy_oe
);
  logic [1:0]  ul;
  logic [3:0]  as_q;
  logic        sec_q;
  logic        xit_q;
  logic        sync_q;
  logic        early_q;
  wire  [7:0]  off = addr[7:0];
  wire         ash = as_q[addr[`FCAC_BANK_HI:`FCAC_BANK_LO]] && !sec_q && !sync_q;
  wire  [15:0] id_exp = (off == `FCAC_AS_DEV1) ? DEV_CODE1 : (off == `FCAC_AS_DEV2) ? DEV_CODE2 : DEV_CODE3;
  wire  [15:0] esn_w = ELECTRONIC_SERIAL_NUMBER[16*addr[2:0] +: 16];
  // shadow cannot see a busy-refused entry, so the bench keeps reads away from it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ul      <= 2'h0;
      as_q    <= 4'h0;
      sec_q   <= 1'h0;
      xit_q   <= 1'h0;
      sync_q  <= 1'h0;
      early_q <= 1'h0;
    end
    else if (!we_n)
    begin
      ul    <= 2'h0;
      xit_q <= 1'h0;
      if (wdata == `FCAC_CMD_RESET)
        as_q <= 4'h0;
      else if (xit_q && wdata == `FCAC_CMD_SEC_EXIT2)
        sec_q <= 1'h0;
      else if (ul == 2'h0 && addr[11:0] == `FCAC_UNLOCK1_ADDR && wdata == `FCAC_UNLOCK1_DATA)
        ul <= 2'h1;
      else if (ul == 2'h1 && addr[11:0] == `FCAC_UNLOCK2_ADDR && wdata == `FCAC_UNLOCK2_DATA)
        ul <= 2'h2;
      else if (ul == 2'h2)
      begin
        if (wdata == `FCAC_CMD_AUTOSEL && sec_q)
          xit_q <= 1'h1;
        if (wdata == `FCAC_CMD_AUTOSEL && !sec_q)
          as_q[addr[`FCAC_BANK_HI:`FCAC_BANK_LO]] <= 1'h1;
        if (wdata == `FCAC_CMD_SEC_ENTER)
          sec_q <= 1'h1;
        if (wdata == `FCAC_CMD_CFG && addr[14:12] < `FCAC_WAIT_RSVD)
        begin
          sync_q  <= !addr[19];
          early_q <= !addr[18];
        end
      end
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  AST_RD_ANSWER: assert property (!re_n |=> rvalid)
    else $error("no data valid after read strobe");
  AST_RD_CAUSE: assert property (rvalid |-> $past(re_n) == 1'h0)
    else $error("data valid without read strobe");
  AST_MFR: assert property (!re_n && ash && off == `FCAC_AS_MFR |=> rdata == MFR_CODE)
    else $error("wrong maker word");
  AST_DEVID: assert property (!re_n && ash && off inside {`FCAC_AS_DEV1, `FCAC_AS_DEV2, `FCAC_AS_DEV3}
    |=> rdata == $past(id_exp))
    else $error("wrong identity word");
  AST_LOCK: assert property (!re_n && ash && off == `FCAC_AS_LOCK |=> rdata[15:1] == 15'h0)
    else $error("lock word not 0 or 1");
  AST_IND: assert property (!re_n && ash && off == `FCAC_AS_IND |=> rdata[15:8] == 8'h0)
    else $error("indicator upper byte not zero");
  AST_ESN: assert property (!re_n && sec_q && as_q == 4'h0 && !sync_q |=> rdata == $past(esn_w))
    else $error("wrong serial word");
  AST_RDY_WITH: assert property (rdy_o && !early_q |-> rvalid)
    else $error("ready apart from data");
  AST_OE_ASYNC: assert property (rdy_oe |-> !sync_q)
    else $error("ready driven in burst mode");
endmodule : fcac_chk

/* File: test_flash_config_autoselect_cmds.sv */
// Purpose: bench of host controller and device joined by the flash bus
// Assumes: single ahb-lite word transfers
// Notes:   identity values arbitrary
`timescale 1ns/1ps
`include "fcac_regs.svh"
module test_flash_config_autoselect_cmds;
  localparam logic [15:0]  MFR = 16'h0c3c; // arbitrary
  localparam logic [15:0]  D1  = 16'h1a2b; // arbitrary
  localparam logic [15:0]  D2  = 16'h3c4d; // arbitrary
  localparam logic [15:0]  D3  = 16'h5e6f; // arbitrary
  localparam logic [127:0] SN  = 128'h8877665544332211f0e0d0c0b0a09080;
  localparam logic [15:0]  ARR = 16'h5a5a;
  logic        hclk       = 1'h0;
  logic        hresetn    = 1'h0;
  logic        hsel       = 1'h0;
  logic [7:0]  haddr      = 8'h0;
  logic [1:0]  htrans     = 2'h0;
  logic        hwrite     = 1'h0;
  logic [31:0] hwdata     = 32'h0;
  logic [3:0]  busy       = 4'h0;
  logic        lim        = 1'h0;
  logic        clr        = 1'h0;
  logic [2:0]  ind        = 3'h5;
  logic [3:0]  ab_seen    = 4'h0;
  int          n_mismatch = 0;
  int          num_checks = 0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        sync_mode;
  logic        rdy_early;
  logic        rising_edge_sel;
  logic        secured_region;
  logic [1:0]  burst_len;
  logic [2:0]  wait_code;
  logic [3:0]  autosel_bank;
  logic [3:0]  abort_bank;
  wire  [7:0]  cfg  = {sync_mode, rdy_early, rising_edge_sel, burst_len, wait_code};
  wire  [7:0]  mode = {3'h0, secured_region, autosel_bank};
  always #2.5 hclk = ~hclk;
  // abort is a one-cycle pulse, so it is caught here
  always @(posedge hclk)
    ab_seen <= (clr || !hresetn) ? 4'h0 : ab_seen | abort_bank;
  fcac_if i_fcac_if ();
  fcac_host i_fcac_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .bus(i_fcac_if.host));
  fcac_device #(.MFR_CODE(MFR), .DEV_CODE1(D1), .DEV_CODE2(D2), .DEV_CODE3(D3), .ELECTRONIC_SERIAL_NUMBER(SN)) i_fcac_device (
    .hclk(hclk), .hresetn(hresetn), .bus(i_fcac_if.device), .array_rdata(ARR), .sector_lock(8'h04),
    .factory_lock(ind[2]), .customer_lock(ind[1]), .reduced_hs(ind[0]), .exceeded_limit_bit(lim),
    .algo_busy(busy), .suspended(4'h0), .sync_mode(sync_mode), .rdy_early(rdy_early),
    .rising_edge_sel(rising_edge_sel), .burst_len(burst_len), .wait_code(wait_code),
    .autosel_bank(autosel_bank), .secured_region(secured_region), .abort_bank(abort_bank));
  fcac_chk #(.MFR_CODE(MFR), .DEV_CODE1(D1), .DEV_CODE2(D2), .DEV_CODE3(D3), .ELECTRONIC_SERIAL_NUMBER(SN)) i_fcac_chk (
    .hclk(hclk), .hresetn(hresetn), .avs_n(i_fcac_if.avs_n), .we_n(i_fcac_if.we_n),
    .re_n(i_fcac_if.re_n), .addr(i_fcac_if.addr), .wdata(i_fcac_if.wdata), .rdata(i_fcac_if.rdata),
    .rvalid(i_fcac_if.rvalid), .rdy_o(i_fcac_if.rdy_o), .rdy_oe(i_fcac_if.rdy_oe));
  task automatic test_done(input logic hang);
    if (hang)
      n_mismatch++;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic hwait;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'h1)
    begin
      n++;
      if (n > 50)
        test_done(1'h1);
      @(posedge hclk);
    end
  endtask : hwait
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'h1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hwait;
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    hwait;
    q = hrdata;
  endtask : ahb
  task automatic rw(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'h1, a, d, q);
  endtask : rw
  task automatic idle;
    logic [31:0] s;
    int          n;
    s = 32'h1;
    n = 0;
    while (s[0] !== 1'h0)
    begin
      ahb(1'h0, `FCAC_HREG_STATUS, 32'h0, s);
      n++;
      if (n > 20)
        test_done(1'h1);
    end
  endtask : idle
  task automatic fw(input logic [19:0] a, input logic [15:0] d);
    rw(`FCAC_HREG_ADDR, {12'h0, a});
    rw(`FCAC_HREG_DATA, {16'h0, d});
    rw(`FCAC_HREG_CTRL, 32'h1);
    idle;
    // config outputs land two edges after the command; let them settle
    @(posedge hclk);
  endtask : fw
  task automatic fr(input logic [19:0] a, output logic [15:0] q);
    logic [31:0] r;
    rw(`FCAC_HREG_ADDR, {12'h0, a});
    rw(`FCAC_HREG_CTRL, 32'h2);
    idle;
    ahb(1'h0, `FCAC_HREG_RDATA, 32'h0, r);
    q = r[15:0];
  endtask : fr
  task automatic unl;
    fw({8'h0, `FCAC_UNLOCK1_ADDR}, `FCAC_UNLOCK1_DATA);
    fw({8'h0, `FCAC_UNLOCK2_ADDR}, `FCAC_UNLOCK2_DATA);
  endtask : unl
  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_w
  task automatic chk_s(input logic [7:0] got, input logic [7:0] exp);
    chk_w({8'h0, got}, {8'h0, exp});
  endtask : chk_s
  initial
  begin : main
    logic [15:0] q;
    logic [7:0]  e;
    logic [7:0]  f [4];
    logic [19:0] oa [8];
    logic [15:0] ox [8];
    f  = '{8'h0b, 8'h1e, 8'h74, 8'hb8};
    oa = '{20'h80000, 20'h80001, 20'h8000e, 20'h8000f, 20'h80000, 20'h90002, 20'h98002, 20'h40000};
    ox = '{MFR, D1, D2, D3, MFR, 16'h0001, 16'h0000, ARR};
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    e = 8'h25;
    chk_s(cfg, e);
    foreach (f[i])
    begin
      unl;
      chk_s(cfg, e);
      fw({f[i], 12'h0}, `FCAC_CMD_CFG);
      // reserved wait codes leave the old setting in place
      if (f[i][2:0] < 3'h6)
        e = {~f[i][7:6], f[i][5:0]};
      chk_s(cfg, e);
    end
    hresetn <= 1'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    chk_s(cfg, 8'h25);
    $display("test config done");
    unl;
    fw(20'h80000, `FCAC_CMD_AUTOSEL);
    chk_s(mode, 8'h04);
    foreach (oa[i])
    begin
      fr(oa[i], q);
      chk_w(q, ox[i]);
    end
    repeat (2)
    begin
      fr(20'h80003, q);
      chk_w(q & 16'hffe0, {8'h0, ind, 5'h0});
      ind <= 3'h2;
    end
    fw(20'h3c3c3, `FCAC_CMD_RESET);
    chk_s(mode, 8'h00);
    fr(20'h80000, q);
    chk_w(q, ARR);
    unl;
    fw(20'h00000, `FCAC_CMD_RESET);
    fw(20'hc0000, `FCAC_CMD_AUTOSEL);
    chk_s(mode, 8'h00);
    $display("test autoselect done");
    unl;
    fw(20'h00000, `FCAC_CMD_SEC_ENTER);
    chk_s(mode, 8'h10);
    for (int i = 0; i < 8; i++)
    begin
      fr(i[19:0], q);
      chk_w(q, SN[16*i +: 16]);
    end
    unl;
    fw(20'h00000, `FCAC_CMD_SEC_EXIT);
    fw(20'h00000, `FCAC_CMD_SEC_EXIT2);
    chk_s(mode, 8'h00);
    fr(20'h00003, q);
    chk_w(q, ARR);
    busy <= 4'h1;
    unl;
    fw(20'h00000, `FCAC_CMD_SEC_ENTER);
    chk_s(mode, 8'h00);
    unl;
    fw(20'h00000, `FCAC_CMD_SEC_EXIT);
    fw(20'h00000, `FCAC_CMD_SEC_EXIT2);
    $display("test region done");
    busy <= 4'h2;
    clr  <= 1'h1;
    @(posedge hclk);
    clr  <= 1'h0;
    // setup aimed at the busy bank, so reset must not abort it
    unl;
    fw(20'h40000, `FCAC_CMD_PROGRAM);
    fw(20'h40000, `FCAC_CMD_RESET);
    chk_s({4'h0, ab_seen}, 8'h00);
    lim <= 1'h1;
    fw(20'h40000, `FCAC_CMD_RESET);
    chk_s({4'h0, ab_seen}, 8'h02);
    busy <= 4'h0;
    lim  <= 1'h0;
    clr  <= 1'h1;
    @(posedge hclk);
    clr  <= 1'h0;
    unl;
    fw(20'h40000, `FCAC_CMD_PROGRAM);
    fw(20'h40000, `FCAC_CMD_RESET);
    chk_s({4'h0, ab_seen}, 8'h02);
    $display("test abort done");
    test_done(1'h0);
  end
endmodule : test_flash_config_autoselect_cmds
